// >>> design/sbr_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sbr_chan_if;
	logic [7:0] rate;
	logic [1:0] cks;
	logic async_mode;
	logic bit_tick;
	logic [7:0] rx_data;
	logic rx_parity;
	logic rx_stop1;
	logic parity_en;
	logic parity_odd;
	logic fer_hit;
	logic per_hit;
	modport rate_mp (input rate, cks, async_mode, output bit_tick);
	modport check_mp (input rx_data, rx_parity, rx_stop1, parity_en, parity_odd, async_mode,
		output fer_hit, per_hit);
	modport top_mp (output rate, cks, async_mode, rx_data, rx_parity, rx_stop1, parity_en,
		parity_odd, input bit_tick, fer_hit, per_hit);
endinterface : sbr_chan_if
`default_nettype wire

// >>> design/sbr_pkg.sv
// What this block does
// RULE1: End of async reception with stop bit 0 sets framing error flag, bit 4.
// RULE2: With two stop bits only the first one is checked.
// RULE3: Framing error still loads receive buffer but leaves receive full unset.
// RULE4: While an error flag is set, reception halts; sync mode also halts transmit.
// RULE5: Error flags clear only by writing 0 after reading them as 1.
// RULE6: Clearing receiver enable leaves error flags unchanged.
// RULE7: Parity mismatch against even/odd setting sets parity error flag, bit 3.
// RULE8: Parity error loads receive buffer without setting receive full.
// RULE9: Transmit end sets on last bit with transmit empty, or transmitter off.
// RULE10: Transmit end clears on software empty-flag clear or engine buffer write.
// RULE11: Transmit end is read-only; register writes never touch it.
// RULE12: Engine write clears only with interrupt-disable 0 and counter nonzero.
// RULE13: Async multiprocessor reception loads received bit into read-only bit 1.
// RULE14: Clearing receiver enable keeps the stored received multiprocessor bit.
// RULE15: Bit 0 is sent as the multiprocessor bit; reset value 0.
// RULE16: Transmit multiprocessor bit is ignored in sync, non-multiprocessor, or idle.
// RULE17: Eight-bit bit-rate register, always readable and writable, sets bit rate.
// RULE18: Bit-rate register forced to all ones on reset, standby, module stop.
// RULE19: Each channel instance owns its own rate generator and register.
// RULE20: Writes of 1 to clearable flags are ignored.
// RULE21: Status register becomes 0x84 on reset, standby and module stop.
// RULE22: Async rate is clock over 64 times 2^(2n-1) times (N+1).
package sbr_pkg;
	localparam int ADDR_W = 2;
	localparam logic [1:0] OFS_STATUS = 2'h0;
	localparam logic [1:0] OFS_BITRATE = 2'h1;
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_RX_FULL = 6;
	localparam int BIT_OVERRUN = 5;
	localparam int BIT_FRAMING = 4;
	localparam int BIT_PARITY = 3;
	localparam int BIT_TX_END = 2;
	localparam int BIT_RX_MP = 1;
	localparam int BIT_TX_MP = 0;
	localparam logic [7:0] STATUS_RESET = 8'h84;
	localparam logic [7:0] RATE_RESET = 8'hFF;
	localparam logic [5:0] PRE_ONE = 6'h01;
	localparam logic [4:0] ASYNC_PHASES = 5'h1F;
	localparam logic [4:0] SYNC_PHASES = 5'h03;
	localparam int ARM_TX_EMPTY = 2;
	localparam int ARM_FRAMING = 1;
	localparam int ARM_PARITY = 0;
endpackage : sbr_pkg

// >>> design/sbr_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sbr_rate_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Rate settings and tick
	sbr_chan_if.rate_mp rif
);
	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] div;
		logic [4:0] phase;
		logic tick;
	} sbr_rate_type;

	sbr_rate_type q, d;
	logic [5:0] pre_top;

	// RULE22 prescale by 4^n
	always_comb begin
		pre_top = 6'((sbr_pkg::PRE_ONE << {rif.cks, 1'b0}) - sbr_pkg::PRE_ONE);
		d = q;
		d.tick = 1'b0;
		if (q.pre >= pre_top) begin
			d.pre = '0;
			if (q.div >= rif.rate) begin
				d.div = '0;
				// RULE22 thirty-two phases per bit in async, four in sync
				if (q.phase >= (rif.async_mode ? sbr_pkg::ASYNC_PHASES : sbr_pkg::SYNC_PHASES)) begin
					d.phase = '0;
					d.tick = 1'b1;
				end else begin
					d.phase = 5'(q.phase + 5'h01);
				end
			end else begin
				d.div = 8'(q.div + 8'h01);
			end
		end else begin
			d.pre = 6'(q.pre + 6'h01);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rif.bit_tick = q.tick;
endmodule : sbr_rate_gen
`default_nettype wire

// >>> design/sbr_rx_check.sv
`timescale 1ns/100ps
`default_nettype none
module sbr_rx_check (
	// Received frame and results
	sbr_chan_if.check_mp cif
);
	// RULE2 only first stop bit
	// RULE1 stop bit zero
	assign cif.fer_hit = cif.async_mode & ~cif.rx_stop1;
	// RULE7 parity count check
	assign cif.per_hit = cif.async_mode & cif.parity_en
		& ((^cif.rx_data ^ cif.rx_parity) != cif.parity_odd);
endmodule : sbr_rx_check
`default_nettype wire

// >>> design/sbr_top.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sbr_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [sbr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	// Low power modes
	input wire logic standby,
	input wire logic module_stop,
	// Mode and control
	input wire logic async_mode,
	input wire logic mp_format,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic [1:0] clk_sel,
	input wire logic rx_on_bit,
	input wire logic tx_on_bit,
	// Flags kept outside
	input wire logic transmit_empty_flag,
	input wire logic receive_full_flag,
	input wire logic overrun_flag,
	// Receiver frame end
	input wire logic rx_done,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity,
	input wire logic rx_stop1,
	input wire logic rx_mp_bit,
	// Transmitter
	input wire logic tx_last_bit,
	// Data transfer engine
	input wire logic engine_tx_write,
	input wire logic chain_irq_disable,
	input wire logic engine_count_nz,
	// Results
	output logic rdb_load_q,
	output logic [7:0] receive_data_buffer_q,
	output logic rdf_set_q,
	output logic empty_clear_q,
	output logic rx_halt_q,
	output logic tx_halt_q,
	output logic tx_mp_bit_q,
	output logic baud_tick_q,
	output logic transmit_end_flag_q
);
	typedef struct packed {
		logic framing;
		logic parity;
		logic tx_end;
		logic rx_mp;
		logic tx_mp;
		logic [7:0] rate;
		logic [2:0] arm;
		logic [7:0] rdata;
		logic rdb_load;
		logic [7:0] rdb_data;
		logic rdf_set;
		logic empty_clr;
		logic rx_halt;
		logic tx_halt;
		logic tx_mp_out;
		logic tick;
	} sbr_state_type;

	sbr_state_type q, d;
	sbr_chan_if cif ();
	logic lp;
	logic rx_ev;
	logic st_wr;
	logic eng_clr;
	logic [7:0] status_view;

	function automatic logic hit(input logic [sbr_pkg::ADDR_W-1:0] a,
		input logic [1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign cif.rate = q.rate;
	assign cif.cks = clk_sel;
	assign cif.async_mode = async_mode;
	assign cif.rx_data = rx_data;
	assign cif.rx_parity = rx_parity;
	assign cif.rx_stop1 = rx_stop1;
	assign cif.parity_en = parity_en;
	assign cif.parity_odd = parity_odd;

	// RULE19 private generator
	sbr_rate_gen u_rate (
		.clk(clk),
		.rst_n(rst_n),
		.rif(cif.rate_mp)
	);

	sbr_rx_check u_check (
		.cif(cif.check_mp)
	);

	assign lp = standby | module_stop;
	// RULE4 no reception while halted
	assign rx_ev = rx_done & ~(q.framing | q.parity);
	assign st_wr = reg_wr & hit(reg_addr, sbr_pkg::OFS_STATUS);
	// RULE12 engine clear qualifier
	assign eng_clr = engine_tx_write & ~chain_irq_disable & engine_count_nz;

	always_comb begin
		status_view = '0;
		status_view[sbr_pkg::BIT_TX_EMPTY] = transmit_empty_flag;
		status_view[sbr_pkg::BIT_RX_FULL] = receive_full_flag;
		status_view[sbr_pkg::BIT_OVERRUN] = overrun_flag;
		status_view[sbr_pkg::BIT_FRAMING] = q.framing;
		status_view[sbr_pkg::BIT_PARITY] = q.parity;
		status_view[sbr_pkg::BIT_TX_END] = q.tx_end;
		status_view[sbr_pkg::BIT_RX_MP] = q.rx_mp;
		status_view[sbr_pkg::BIT_TX_MP] = q.tx_mp;
	end

	always_comb begin
		d = q;
		d.rdb_load = 1'b0;
		d.rdf_set = 1'b0;
		d.empty_clr = 1'b0;
		d.rdata = '0;
		d.tick = cif.bit_tick;
		// RULE5 read as one arms the clear
		if (reg_rd && hit(reg_addr, sbr_pkg::OFS_STATUS)) begin
			d.arm = {transmit_empty_flag, q.framing, q.parity};
		end else if (st_wr) begin
			d.arm = '0;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				sbr_pkg::OFS_STATUS: d.rdata = status_view;
				sbr_pkg::OFS_BITRATE: d.rdata = q.rate;
				default: d.rdata = '0;
			endcase
		end
		// RULE20 only zero writes clear
		// RULE5 clear after armed read
		if (st_wr && !reg_wdata[sbr_pkg::BIT_FRAMING] && q.arm[sbr_pkg::ARM_FRAMING]) begin
			d.framing = 1'b0;
		end
		if (st_wr && !reg_wdata[sbr_pkg::BIT_PARITY] && q.arm[sbr_pkg::ARM_PARITY]) begin
			d.parity = 1'b0;
		end
		if (st_wr && !reg_wdata[sbr_pkg::BIT_TX_EMPTY] && q.arm[sbr_pkg::ARM_TX_EMPTY]) begin
			d.empty_clr = 1'b1;
		end
		// RULE15 software sets bit 0
		if (st_wr) begin
			d.tx_mp = reg_wdata[sbr_pkg::BIT_TX_MP];
		end
		// RULE17 bit-rate write
		if (reg_wr && hit(reg_addr, sbr_pkg::OFS_BITRATE)) begin
			d.rate = reg_wdata;
		end
		// RULE6 receiver enable not consulted
		if (rx_ev) begin
			// RULE3 buffer still loaded
			// RULE8 full flag withheld on error
			d.rdb_load = 1'b1;
			d.rdb_data = rx_data;
			d.rdf_set = ~(cif.fer_hit | cif.per_hit);
			// RULE1 set wins over clear
			if (cif.fer_hit) begin
				d.framing = 1'b1;
			end
			// RULE7 set wins over clear
			if (cif.per_hit) begin
				d.parity = 1'b1;
			end
			// RULE13 store received bit
			if (async_mode && mp_format) begin
				d.rx_mp = rx_mp_bit;
			end
		end
		// RULE11 only hardware moves it
		// RULE10 clear sources
		if (d.empty_clr || eng_clr) begin
			d.tx_end = 1'b0;
		end
		// RULE9 set wins over clear
		if ((tx_last_bit && transmit_empty_flag) || !tx_on_bit) begin
			d.tx_end = 1'b1;
		end
		// RULE21 status back to 0x84
		// RULE18 bit rate back to ones
		if (lp) begin
			d.framing = sbr_pkg::STATUS_RESET[sbr_pkg::BIT_FRAMING];
			d.parity = sbr_pkg::STATUS_RESET[sbr_pkg::BIT_PARITY];
			d.tx_end = sbr_pkg::STATUS_RESET[sbr_pkg::BIT_TX_END];
			d.rx_mp = sbr_pkg::STATUS_RESET[sbr_pkg::BIT_RX_MP];
			d.tx_mp = sbr_pkg::STATUS_RESET[sbr_pkg::BIT_TX_MP];
			d.rate = sbr_pkg::RATE_RESET;
			d.arm = '0;
			d.empty_clr = 1'b0;
		end
		// RULE4 halt outputs
		d.rx_halt = d.framing | d.parity;
		d.tx_halt = ~async_mode & (d.framing | d.parity);
		// RULE16 effective only when used
		d.tx_mp_out = d.tx_mp & async_mode & mp_format & tx_on_bit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.tx_end <= sbr_pkg::STATUS_RESET[sbr_pkg::BIT_TX_END];
			q.rate <= sbr_pkg::RATE_RESET;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_q = q.rdata;
	assign rdb_load_q = q.rdb_load;
	assign receive_data_buffer_q = q.rdb_data;
	assign rdf_set_q = q.rdf_set;
	assign empty_clear_q = q.empty_clr;
	assign rx_halt_q = q.rx_halt;
	assign tx_halt_q = q.tx_halt;
	assign tx_mp_bit_q = q.tx_mp_out;
	assign baud_tick_q = q.tick;
	assign transmit_end_flag_q = q.tx_end;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_fer_set;
		rx_ev && cif.fer_hit && !lp |=> q.framing && rx_halt_q;
	endproperty
	a_fer_set: assert property (p_fer_set) else $error("framing error not flagged"); // RULE1

	property p_stop2;
		rx_ev && rx_stop1 && !cif.per_hit && !lp |=> !q.framing;
	endproperty
	a_stop2: assert property (p_stop2) else $error("good stop bit flagged"); // RULE2

	property p_err_load;
		rx_ev && (cif.fer_hit || cif.per_hit) |=> rdb_load_q && !rdf_set_q;
	endproperty
	a_err_load: assert property (p_err_load) else $error("error frame load wrong"); // RULE3

	property p_halt;
		rx_done && (q.framing || q.parity) |=> !rdb_load_q;
	endproperty
	a_halt: assert property (p_halt) else $error("reception during error"); // RULE4

	property p_clear_read;
		q.framing && !q.arm[sbr_pkg::ARM_FRAMING] && !lp |=> q.framing;
	endproperty
	a_clear_read: assert property (p_clear_read) else $error("unarmed clear of framing"); // RULE5

	property p_transmit_end_flag_off;
		!tx_on_bit && !lp ##1 !tx_on_bit [*2] |-> transmit_end_flag_q;
	endproperty
	a_transmit_end_flag_off: assert property (p_transmit_end_flag_off) else $error("transmit end low, tx off"); // RULE9

	property p_engine;
		eng_clr && tx_on_bit && !tx_last_bit && !lp |=> !transmit_end_flag_q;
	endproperty
	a_engine: assert property (p_engine) else $error("engine write kept end flag"); // RULE12

	property p_mpb_keep;
		!rx_done && !lp |=> $stable(q.rx_mp);
	endproperty
	a_mpb_keep: assert property (p_mpb_keep) else $error("received mp bit moved"); // RULE14

	property p_transmit_mp_bit_sync;
		!async_mode |=> !tx_mp_bit_q;
	endproperty
	a_transmit_mp_bit_sync: assert property (p_transmit_mp_bit_sync) else $error("mp bit sent in sync"); // RULE16

	property p_rate_lp;
		lp |=> q.rate == sbr_pkg::RATE_RESET;
	endproperty
	a_rate_lp: assert property (p_rate_lp) else $error("bit rate not all ones"); // RULE18

	property p_par_set;
		rx_ev && cif.per_hit && !lp |=> q.parity && rx_halt_q;
	endproperty
	a_par_set: assert property (p_par_set) else $error("parity error not flagged"); // RULE7

	property p_par_load;
		rx_ev && cif.per_hit |=> rdb_load_q && !rdf_set_q;
	endproperty
	a_par_load: assert property (p_par_load) else $error("parity frame load wrong"); // RULE8

	property p_good_load;
		rx_ev && !cif.fer_hit && !cif.per_hit |=> rdb_load_q && rdf_set_q
			&& receive_data_buffer_q == $past(rx_data);
	endproperty
	a_good_load: assert property (p_good_load) else $error("good frame load wrong"); // RULE3

	property p_par_clear;
		q.parity && !q.arm[sbr_pkg::ARM_PARITY] && !lp |=> q.parity;
	endproperty
	a_par_clear: assert property (p_par_clear) else $error("unarmed clear of parity"); // RULE5

	property p_end_clear;
		st_wr && !reg_wdata[sbr_pkg::BIT_TX_EMPTY] && q.arm[sbr_pkg::ARM_TX_EMPTY] && tx_on_bit
			&& !tx_last_bit && !lp |=> !transmit_end_flag_q && empty_clear_q;
	endproperty
	a_end_clear: assert property (p_end_clear) else $error("armed clear kept end flag"); // RULE10

	property p_end_ro;
		st_wr && reg_wdata[sbr_pkg::BIT_TX_EMPTY] && !eng_clr && tx_on_bit && !tx_last_bit
			&& !lp |=> $stable(q.tx_end);
	endproperty
	a_end_ro: assert property (p_end_ro) else $error("write moved end flag"); // RULE11

	property p_mp_load;
		rx_ev && async_mode && mp_format && !lp |=> q.rx_mp == $past(rx_mp_bit);
	endproperty
	a_mp_load: assert property (p_mp_load) else $error("received mp bit not stored"); // RULE13

	property p_mp_send;
		st_wr && async_mode && mp_format && tx_on_bit && !lp
			|=> tx_mp_bit_q == $past(reg_wdata[sbr_pkg::BIT_TX_MP]);
	endproperty
	a_mp_send: assert property (p_mp_send) else $error("mp bit not sent"); // RULE15

	property p_rate_wr;
		reg_wr && hit(reg_addr, sbr_pkg::OFS_BITRATE) && !lp |=> q.rate == $past(reg_wdata);
	endproperty
	a_rate_wr: assert property (p_rate_wr) else $error("bit rate write lost"); // RULE17

	property p_one_ignored;
		st_wr && reg_wdata[sbr_pkg::BIT_FRAMING] && !q.framing && !rx_ev |=> !q.framing;
	endproperty
	a_one_ignored: assert property (p_one_ignored) else $error("write of one set flag"); // RULE20

	property p_status_lp;
		lp |=> q.tx_end && !q.framing && !q.parity && !q.rx_mp && !q.tx_mp;
	endproperty
	a_status_lp: assert property (p_status_lp) else $error("status not back to reset"); // RULE21

	property p_rx_enable;
		!rx_on_bit && !rx_done && !st_wr && !lp |=> $stable(q.framing) && $stable(q.parity);
	endproperty
	a_rx_enable: assert property (p_rx_enable) else $error("error flag moved, rx off"); // RULE6

	property p_tick_pulse;
		baud_tick_q |=> !baud_tick_q;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("bit tick too long"); // RULE22
endmodule : sbr_top
`default_nettype wire

// >>> test/sbr_remote_station.sv
`timescale 1ns/100ps
`default_nettype none
module sbr_remote_station (
	// Clock
	input wire logic clk,
	// Frame end toward the receiver
	output logic rx_done,
	output logic [7:0] rx_data,
	output logic rx_parity,
	output logic rx_stop1,
	output logic rx_mp_bit
);
	initial begin
		rx_done = 1'b0;
		rx_data = 8'h00;
		rx_parity = 1'b0;
		rx_stop1 = 1'b1;
		rx_mp_bit = 1'b0;
	end
	task automatic send(input logic [7:0] d, input logic p, s, m);
		@(posedge clk);
		rx_done <= 1'b1;
		rx_data <= d;
		rx_parity <= p;
		rx_stop1 <= s;
		rx_mp_bit <= m;
		@(posedge clk);
		rx_done <= 1'b0;
		rx_data <= ~d;
		rx_parity <= ~p;
		rx_stop1 <= ~s;
		rx_mp_bit <= ~m;
	endtask : send
endmodule : sbr_remote_station
`default_nettype wire

// >>> test/serial_status_and_bit_rate_test.sv
`timescale 1ns/100ps
`default_nettype none
module serial_status_and_bit_rate_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] reg_addr, clk_sel;
	logic [7:0] reg_wdata, reg_rdata_q, rx_data, receive_data_buffer_q;
	logic reg_wr, reg_rd, standby, module_stop, async_mode, mp_format, parity_en, parity_odd;
	logic rx_on_bit, tx_on_bit, transmit_empty_flag, receive_full_flag, overrun_flag;
	logic rx_done, rx_parity, rx_stop1, rx_mp_bit, tx_last_bit, engine_tx_write;
	logic chain_irq_disable, engine_count_nz, rdb_load_q, rdf_set_q, empty_clear_q;
	logic rx_halt_q, tx_halt_q, tx_mp_bit_q, baud_tick_q, transmit_end_flag_q;
	int failures = 0;
	int comparisons = 0;
	always #10 clk = ~clk;
	sbr_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
		.standby, .module_stop, .async_mode, .mp_format, .parity_en, .parity_odd, .clk_sel,
		.rx_on_bit, .tx_on_bit, .transmit_empty_flag, .receive_full_flag, .overrun_flag,
		.rx_done, .rx_data, .rx_parity, .rx_stop1, .rx_mp_bit, .tx_last_bit,
		.engine_tx_write, .chain_irq_disable, .engine_count_nz, .rdb_load_q,
		.receive_data_buffer_q, .rdf_set_q, .empty_clear_q, .rx_halt_q, .tx_halt_q,
		.tx_mp_bit_q, .baud_tick_q, .transmit_end_flag_q);
	sbr_remote_station rs (.clk, .rx_done, .rx_data, .rx_parity, .rx_stop1, .rx_mp_bit);
	task automatic close_out;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic chkv(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chkv
	task automatic chk1(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk1
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chkv(16'(reg_rdata_q), 16'(e));
	endtask : rd
	task automatic frame(input logic [7:0] d, input logic p, s, m, el, er);
		rs.send(d, p, s, m);
		#1;
		chk1(rdb_load_q, el);
		chk1(rdf_set_q, er);
	endtask : frame
	task automatic eng(input logic c, input logic z, input logic e);
		@(posedge clk);
		engine_tx_write <= 1'b1;
		chain_irq_disable <= c;
		engine_count_nz <= z;
		@(posedge clk);
		engine_tx_write <= 1'b0;
		#1;
		chk1(transmit_end_flag_q, e);
	endtask : eng
	task automatic last(input logic t, input logic e);
		@(posedge clk);
		tx_last_bit <= 1'b1;
		transmit_empty_flag <= t;
		@(posedge clk);
		tx_last_bit <= 1'b0;
		transmit_empty_flag <= 1'b1;
		#1;
		chk1(transmit_end_flag_q, e);
	endtask : last
	task automatic period(input logic [15:0] e);
		int n;
		repeat (2) begin
			n = 1;
			@(posedge clk) #1;
			while (baud_tick_q !== 1'b1 && n < 9000) begin
				@(posedge clk) #1;
				n++;
			end
		end
		chkv(16'(n), e);
	endtask : period
	task automatic t_fer;
		frame(8'hA5, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		chkv(16'(receive_data_buffer_q), 16'h00A5);
		chk1(rx_halt_q, 1'b1);
		frame(8'h11, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge clk);
		async_mode <= 1'b0;
		rx_on_bit <= 1'b0;
		cyc(1);
		chk1(tx_halt_q, 1'b1);
		@(posedge clk);
		async_mode <= 1'b1;
		wr(2'h0, 8'hEE);
		rd(2'h0, 8'h94);
		wr(2'h0, 8'hEE);
		rd(2'h0, 8'h84);
		wr(2'h0, 8'hFE);
		rd(2'h0, 8'h84);
		@(posedge clk);
		rx_on_bit <= 1'b1;
	endtask : t_fer
	task automatic t_par;
		@(posedge clk);
		parity_en <= 1'b1;
		for (int o = 0; o < 2; o++) begin
			@(posedge clk);
			parity_odd <= 1'(o);
			frame(8'h03, 1'(o), 1'b1, 1'b0, 1'b1, 1'b1);
			frame(8'h03, 1'(1 - o), 1'b1, 1'b0, 1'b1, 1'b0);
			rd(2'h0, 8'h8C);
			wr(2'h0, 8'hF6);
		end
		@(posedge clk);
		parity_en <= 1'b0;
	endtask : t_par
	task automatic t_mp;
		@(posedge clk);
		mp_format <= 1'b1;
		frame(8'h5A, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		@(posedge clk);
		rx_on_bit <= 1'b0;
		wr(2'h0, 8'hFC);
		rd(2'h0, 8'h86);
		wr(2'h0, 8'hFF);
		cyc(1);
		chk1(tx_mp_bit_q, 1'b1);
		rd(2'h0, 8'h87);
		@(posedge clk);
		mp_format <= 1'b0;
		cyc(1);
		chk1(tx_mp_bit_q, 1'b0);
		@(posedge clk);
		mp_format <= 1'b1;
		tx_on_bit <= 1'b0;
		cyc(1);
		chk1(tx_mp_bit_q, 1'b0);
		frame(8'h5A, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
		wr(2'h0, 8'hFE);
		rd(2'h0, 8'h84);
		@(posedge clk);
		rx_on_bit <= 1'b1;
		mp_format <= 1'b0;
	endtask : t_mp
	task automatic t_transmit_end_flag;
		@(posedge clk);
		tx_on_bit <= 1'b1;
		eng(1'b1, 1'b1, 1'b1);
		eng(1'b0, 1'b0, 1'b1);
		eng(1'b0, 1'b1, 1'b0);
		wr(2'h0, 8'hFE);
		chk1(transmit_end_flag_q, 1'b0);
		last(1'b0, 1'b0);
		last(1'b1, 1'b1);
		wr(2'h0, 8'hFA);
		chk1(transmit_end_flag_q, 1'b1);
		rd(2'h0, 8'h84);
		wr(2'h0, 8'h7E);
		chk1(empty_clear_q, 1'b1);
		chk1(transmit_end_flag_q, 1'b0);
		@(posedge clk);
		tx_on_bit <= 1'b0;
		cyc(1);
		chk1(transmit_end_flag_q, 1'b1);
	endtask : t_transmit_end_flag
	task automatic t_rate;
		wr(2'h1, 8'h03);
		rd(2'h1, 8'h03);
		period(16'd128);
		@(posedge clk);
		async_mode <= 1'b0;
		clk_sel <= 2'h1;
		period(16'd64);
		@(posedge clk);
		async_mode <= 1'b1;
		clk_sel <= 2'h0;
		for (int k = 0; k < 2; k++) begin
			wr(2'h1, 8'h03);
			wr(2'h0, 8'h01);
			@(posedge clk);
			standby <= (k == 0);
			module_stop <= (k == 1);
			@(posedge clk);
			standby <= 1'b0;
			module_stop <= 1'b0;
			rd(2'h1, 8'hFF);
			rd(2'h0, 8'h84);
		end
	endtask : t_rate
	initial begin
		{reg_addr, clk_sel, reg_wdata, reg_wr, reg_rd, standby, module_stop} = '0;
		{mp_format, parity_en, parity_odd, receive_full_flag, overrun_flag} = '0;
		{tx_last_bit, engine_tx_write, chain_irq_disable, engine_count_nz} = '0;
		{async_mode, rx_on_bit, tx_on_bit, transmit_empty_flag} = 4'hF;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(2'h0, 8'h84);
		rd(2'h1, 8'hFF);
		rd(2'h2, 8'h00);
		wr(2'h3, 8'h00);
		t_fer();
		t_par();
		t_mp();
		t_transmit_end_flag();
		t_rate();
		close_out();
	end
	initial begin
		#200000;
		failures++;
		close_out();
	end
endmodule : serial_status_and_bit_rate_test
`default_nettype wire
